// ---- design/umc_pkg.sv ----
package umc_pkg;

   // Register byte offsets
   localparam logic [7:0] UMC_OFS_CMD_A  = 8'h00;
   localparam logic [7:0] UMC_OFS_CMD_B  = 8'h04;
   localparam logic [7:0] UMC_OFS_STATUS = 8'h08;

   // Command nibble position inside the written byte
   localparam int UMC_CMD_HI = 7;
   localparam int UMC_CMD_LO = 4;

   // Command codes of the upper nibble
   localparam logic [3:0] UMC_CMD_SET_RX_EXT = 4'h8;
   localparam logic [3:0] UMC_CMD_CLR_RX_EXT = 4'h9;
   localparam logic [3:0] UMC_CMD_SET_TX_EXT = 4'ha;
   localparam logic [3:0] UMC_CMD_CLR_TX_EXT = 4'hb;
   localparam logic [3:0] UMC_CMD_STANDBY    = 4'hc;
   localparam logic [3:0] UMC_CMD_ACTIVE     = 4'hd;

   // Status register field positions
   localparam int UMC_ST_STANDBY  = 0;
   localparam int UMC_ST_ZMODE    = 1;
   localparam int UMC_ST_IUS      = 2;
   localparam int UMC_ST_CHAIN_EN = 3;
   localparam int UMC_ST_RX_EXT_A = 4;
   localparam int UMC_ST_TX_EXT_A = 5;
   localparam int UMC_ST_RX_EXT_B = 6;
   localparam int UMC_ST_TX_EXT_B = 7;

   // Reset values
   localparam logic       UMC_RST_EXT     = 1'b0;
   localparam logic       UMC_RST_STANDBY = 1'b0;
   localparam logic       UMC_RST_ZMODE   = 1'b0;
   localparam logic       UMC_RST_IUS     = 1'b0;
   localparam logic [7:0] UMC_RST_CMD     = 8'h00;

   // AHB-Lite encodings
   localparam logic [1:0] UMC_HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] UMC_HTRANS_SEQ    = 2'b11;
   localparam logic [2:0] UMC_HSIZE_WORD    = 3'b010;
   localparam logic       UMC_HRESP_OKAY    = 1'b0;

endpackage : umc_pkg

// ---- design/umc_ext_bits.sv ----
// Per-channel bit-rate-table extension bits driven by channel commands
module umc_ext_bits
   import umc_pkg::*;
(
   input  wire logic       mclk_i,     // Device clock
   input  wire logic       rst_i,      // Synchronous reset, active high
   input  wire logic       cmd_vld_i,  // One-cycle command strobe for this channel
   input  wire logic [3:0] cmd_i,      // Command nibble
   output logic            rx_ext_o,   // Receiver rate extension bit
   output logic            tx_ext_o    // Transmitter rate extension bit
);

   logic rx_ext_q;
   logic tx_ext_q;

   // Receiver extension bit
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rx_ext_q <= UMC_RST_EXT;
      end else if (cmd_vld_i && cmd_i == UMC_CMD_SET_RX_EXT) begin
         rx_ext_q <= 1'b1;
      end else if (cmd_vld_i && cmd_i == UMC_CMD_CLR_RX_EXT) begin
         rx_ext_q <= 1'b0;
      end
   end

   // Transmitter extension bit
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tx_ext_q <= UMC_RST_EXT;
      end else if (cmd_vld_i && cmd_i == UMC_CMD_SET_TX_EXT) begin
         tx_ext_q <= 1'b1;
      end else if (cmd_vld_i && cmd_i == UMC_CMD_CLR_TX_EXT) begin
         tx_ext_q <= 1'b0;
      end
   end

   assign rx_ext_o = rx_ext_q;
   assign tx_ext_o = tx_ext_q;

endmodule : umc_ext_bits

// ---- design/umc_cmd_decoder.sv ----
// Miscellaneous command decoder with AHB-Lite access to the command registers
module umc_cmd_decoder
   import umc_pkg::*;
(
   input  wire logic        mclk_i,        // Device clock, 200 MHz
   input  wire logic        rst_i,         // Synchronous reset, active high
   // AHB-Lite slave
   input  wire logic        hsel_i,        // Slave select
   input  wire logic [31:0] haddr_i,       // Byte address
   input  wire logic [1:0]  htrans_i,      // Transfer type
   input  wire logic        hwrite_i,      // Write when high
   input  wire logic [2:0]  hsize_i,       // Transfer size
   input  wire logic [31:0] hwdata_i,      // Write data
   input  wire logic        hready_i,      // Bus ready
   output logic             hreadyout_o,   // Slave ready
   output logic             hresp_o,       // Response, always OKAY
   output logic [31:0]      hrdata_o,      // Read data
   // Interrupt daisy chain
   input  wire logic        ius_set_i,     // Acknowledge accepted, sets latch in daisy-chained mode only
   output logic             chain_en_o,    // Daisy-chain enable out
   output logic             zmode_o,       // Daisy-chained vectored mode active
   // Chip-wide power and rate table controls
   output logic             standby_o,     // Chip in standby
   output logic             tx_run_o,      // Transmitters powered
   output logic             rx_run_o,      // Receivers powered
   output logic             timer_run_o,   // Counter/timer powered
   output logic             rx_ext_a_o,    // Channel A receiver extension bit
   output logic             tx_ext_a_o,    // Channel A transmitter extension bit
   output logic             rx_ext_b_o,    // Channel B receiver extension bit
   output logic             tx_ext_b_o     // Channel B transmitter extension bit
);

   // Address phase capture
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       rd_hit;
   logic       wr_hit;

   // Command strobes and decoded nibble
   logic       cmd_a_vld;
   logic       cmd_b_vld;
   logic [3:0] cmd_nib;
   logic       cmd_reserved;

   // Chip state
   logic       standby_q;
   logic       zmode_q;
   logic       ius_q;
   logic       ius_d;
   logic       chain_en_q;
   logic [7:0] last_cmd_a_q;
   logic [7:0] last_cmd_b_q;
   logic [31:0] hrdata_q;
   logic [7:0] status;

   // Extension bits from both channels
   logic       rx_ext_a;
   logic       tx_ext_a;
   logic       rx_ext_b;
   logic       tx_ext_b;

   // Valid transfer in its address phase, whole words only
   assign rd_hit = hsel_i && hready_i && !hwrite_i && hsize_i == UMC_HSIZE_WORD
                   && (htrans_i == UMC_HTRANS_NONSEQ || htrans_i == UMC_HTRANS_SEQ);
   assign wr_hit = hsel_i && hready_i && hwrite_i && hsize_i == UMC_HSIZE_WORD
                   && (htrans_i == UMC_HTRANS_NONSEQ || htrans_i == UMC_HTRANS_SEQ);

   // Remember a write until its data phase
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (hready_i) begin
         wr_pend_q <= wr_hit;
         wr_addr_q <= haddr_i[7:0];
      end
   end

   // Decode the upper nibble of a command register write
   assign cmd_nib      = hwdata_i[UMC_CMD_HI:UMC_CMD_LO];
   assign cmd_reserved = cmd_nib[3] && cmd_nib[2] && cmd_nib[1];
   assign cmd_a_vld    = wr_pend_q && hready_i && wr_addr_q == UMC_OFS_CMD_A
                         && !cmd_reserved;
   assign cmd_b_vld    = wr_pend_q && hready_i && wr_addr_q == UMC_OFS_CMD_B
                         && !cmd_reserved;

   // Last byte written to each command register, readable back
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         last_cmd_a_q <= UMC_RST_CMD;
         last_cmd_b_q <= UMC_RST_CMD;
      end else begin
         if (wr_pend_q && hready_i && wr_addr_q == UMC_OFS_CMD_A) begin
            last_cmd_a_q <= hwdata_i[7:0];
         end
         if (wr_pend_q && hready_i && wr_addr_q == UMC_OFS_CMD_B) begin
            last_cmd_b_q <= hwdata_i[7:0];
         end
      end
   end

   // Channel A extension bits
   umc_ext_bits u_ext_a (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .cmd_vld_i (cmd_a_vld),
      .cmd_i     (cmd_nib),
      .rx_ext_o  (rx_ext_a),
      .tx_ext_o  (tx_ext_a)
   );

   // Channel B extension bits
   umc_ext_bits u_ext_b (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .cmd_vld_i (cmd_b_vld),
      .cmd_i     (cmd_nib),
      .rx_ext_o  (rx_ext_b),
      .tx_ext_o  (tx_ext_b)
   );

   // Chip-wide standby, entered and left through channel A only
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         standby_q <= UMC_RST_STANDBY;
      end else if (cmd_a_vld && cmd_nib == UMC_CMD_STANDBY) begin
         standby_q <= 1'b1;
      end else if (cmd_a_vld && cmd_nib == UMC_CMD_ACTIVE) begin
         standby_q <= 1'b0;
      end
   end

   // Power gating of all channels and the timer follows standby
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tx_run_o    <= 1'b1;
         rx_run_o    <= 1'b1;
         timer_run_o <= 1'b1;
      end else if (cmd_a_vld && cmd_nib == UMC_CMD_STANDBY) begin
         tx_run_o    <= 1'b0;
         rx_run_o    <= 1'b0;
         timer_run_o <= 1'b0;
      end else if (cmd_a_vld && cmd_nib == UMC_CMD_ACTIVE) begin
         tx_run_o    <= 1'b1;
         rx_run_o    <= 1'b1;
         timer_run_o <= 1'b1;
      end
   end

   // Daisy-chained mode, entered through channel B, left only by reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         zmode_q <= UMC_RST_ZMODE;
      end else if (cmd_b_vld && cmd_nib == UMC_CMD_ACTIVE) begin
         zmode_q <= 1'b1;
      end
   end

   // Interrupt-under-service latch; an acknowledge beats a same-cycle clear
   always_comb begin
      ius_d = ius_q;
      if (cmd_b_vld && cmd_nib == UMC_CMD_STANDBY && zmode_q) begin
         ius_d = 1'b0;
      end
      if (ius_set_i && zmode_q) begin
         ius_d = 1'b1;
      end
   end

   // Latch and its chain enable update together
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ius_q      <= UMC_RST_IUS;
         chain_en_q <= 1'b1;
      end else begin
         ius_q      <= ius_d;
         chain_en_q <= !ius_d;
      end
   end

   // Status word
   always_comb begin
      status                   = 8'h00;
      status[UMC_ST_STANDBY]   = standby_q;
      status[UMC_ST_ZMODE]     = zmode_q;
      status[UMC_ST_IUS]       = ius_q;
      status[UMC_ST_CHAIN_EN]  = chain_en_q;
      status[UMC_ST_RX_EXT_A]  = rx_ext_a;
      status[UMC_ST_TX_EXT_A]  = tx_ext_a;
      status[UMC_ST_RX_EXT_B]  = rx_ext_b;
      status[UMC_ST_TX_EXT_B]  = tx_ext_b;
   end

   // Read data registered at the end of the address phase
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_hit) begin
         case (haddr_i[7:0])
            UMC_OFS_CMD_A:  hrdata_q <= {24'h00_0000, last_cmd_a_q};
            UMC_OFS_CMD_B:  hrdata_q <= {24'h00_0000, last_cmd_b_q};
            UMC_OFS_STATUS: hrdata_q <= {24'h00_0000, status};
            default:        hrdata_q <= 32'h0000_0000;
         endcase
      end else if (hready_i) begin
         hrdata_q <= 32'h0000_0000;
      end
   end

   // Zero-wait slave: ready and OKAY from reset onward
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= UMC_HRESP_OKAY;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= UMC_HRESP_OKAY;
      end
   end

   // Registered copies of the four extension bits for the outputs
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rx_ext_a_o <= UMC_RST_EXT;
         tx_ext_a_o <= UMC_RST_EXT;
         rx_ext_b_o <= UMC_RST_EXT;
         tx_ext_b_o <= UMC_RST_EXT;
      end else begin
         rx_ext_a_o <= rx_ext_a;
         tx_ext_a_o <= tx_ext_a;
         rx_ext_b_o <= rx_ext_b;
         tx_ext_b_o <= tx_ext_b;
      end
   end

   assign hrdata_o   = hrdata_q;
   assign chain_en_o = chain_en_q;
   assign zmode_o    = zmode_q;
   assign standby_o  = standby_q;

endmodule : umc_cmd_decoder

// ---- verification/umc_cmd_decoder_assertions.sv ----
// Checker on the decoder ports
module umc_cmd_decoder_assertions
   import umc_pkg::*;
(
   input  wire logic        mclk_i,      // Device clock
   input  wire logic        rst_i,       // Synchronous reset
   input  wire logic        hsel_i,      // Slave select
   input  wire logic [31:0] haddr_i,     // Byte address
   input  wire logic [1:0]  htrans_i,    // Transfer type
   input  wire logic        hwrite_i,    // Write flag
   input  wire logic [2:0]  hsize_i,     // Transfer size
   input  wire logic [31:0] hwdata_i,    // Write data
   input  wire logic        hready_i,    // Bus ready
   input  wire logic        ius_set_i,   // Latch set request
   input  wire logic        chain_en_o,  // Chain enable out
   input  wire logic        zmode_o,     // Daisy mode
   input  wire logic        standby_o,   // Standby
   input  wire logic        tx_run_o,    // Transmitters powered
   input  wire logic        rx_run_o,    // Receivers powered
   input  wire logic        timer_run_o, // Timer powered
   input  wire logic        rx_ext_a_o,  // Channel A receiver extension
   input  wire logic        tx_ext_a_o,  // Channel A transmitter extension
   input  wire logic        tx_ext_b_o,  // Channel B transmitter extension
   input  wire logic        rx_ext_b_o,  // Channel B receiver extension
   input  wire logic        hreadyout_o, // Slave ready
   input  wire logic        hresp_o      // Slave response
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       aw_q; // Write address phase taken
   logic [7:0] ad_q; // Its byte offset
   logic       da;   // Data phase of a channel A command
   logic       db;   // Data phase of a channel B command
   logic [3:0] cmd;  // Command nibble in the data phase

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // Remember write address phases
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         aw_q <= 1'b0;
      else
         aw_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == UMC_HSIZE_WORD;
      ad_q <= haddr_i[7:0];
   end

   // Decode the data phase
   assign da = aw_q && ad_q == UMC_OFS_CMD_A;
   assign db = aw_q && ad_q == UMC_OFS_CMD_B;
   assign cmd = hwdata_i[7:4];

   a_standby_enter: assert property (
      da && cmd == UMC_CMD_STANDBY |=> standby_o) else $error("standby not entered");
   a_standby_gates: assert property (
      tx_run_o == !standby_o && rx_run_o == !standby_o && timer_run_o == !standby_o)
      else $error("run outputs disagree with standby");
   a_active_leave: assert property (
      da && cmd == UMC_CMD_ACTIVE |=> !standby_o) else $error("standby not left");
   a_zmode_enter: assert property (
      db && cmd == UMC_CMD_ACTIVE |=> zmode_o) else $error("daisy mode not entered");
   a_chain_release: assert property (
      db && cmd == UMC_CMD_STANDBY && zmode_o && !ius_set_i |=> chain_en_o)
      else $error("chain enable not raised");
   a_rx_clear: assert property (
      da && cmd == UMC_CMD_CLR_RX_EXT |=> ##1 !rx_ext_a_o) else $error("rx ext not cleared");
   a_tx_set: assert property (
      db && cmd == UMC_CMD_SET_TX_EXT |=> ##1 tx_ext_b_o) else $error("tx ext not set");
   a_tx_clear: assert property (
      da && cmd == UMC_CMD_CLR_TX_EXT |=> ##1 !tx_ext_a_o) else $error("tx ext not cleared");
   a_reserved_ignored: assert property (
      (da || db) && cmd[3:1] == 3'h7 |=> $stable(standby_o) && $stable(zmode_o))
      else $error("reserved code acted");
   a_reset_values: assert property (disable iff (1'b0)
      rst_i [*2] |=> chain_en_o && !zmode_o && !standby_o && !rx_ext_a_o && !tx_ext_b_o)
      else $error("wrong state after reset");
   a_rx_clear_b: assert property (
      db && cmd == UMC_CMD_CLR_RX_EXT |=> ##1 !rx_ext_b_o) else $error("rx ext b not cleared");
   a_latch_set: assert property (
      ius_set_i && zmode_o |=> !chain_en_o) else $error("chain enable not lowered");
   a_bus_okay: assert property (
      hreadyout_o && hresp_o == UMC_HRESP_OKAY) else $error("bus not ready or not okay");
endmodule : umc_cmd_decoder_assertions

bind umc_cmd_decoder umc_cmd_decoder_assertions chk_u (.*);

// ---- verification/umc_chain_peer.sv ----
// Upstream daisy-chain neighbour raising an acknowledge into the latch
module umc_chain_peer (
   input  wire logic mclk_i,          // Device clock
   input  wire logic ack_i,           // Request from the bench
   output logic      ius_set_o = 1'b0 // Acknowledge accepted
);
   timeunit 1ns;
   timeprecision 100ps;
   // Registered one-cycle acknowledge
   always @(posedge mclk_i) begin
      ius_set_o <= ack_i;
   end
endmodule : umc_chain_peer

// ---- verification/test_uart_misc_command_decoder.sv ----
// Self-checking bench for the command decoder
module test_uart_misc_command_decoder
   import umc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, ack = 1'b0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
   logic [1:0]  htrans_i = 2'b00;
   logic [2:0]  hsize_i = UMC_HSIZE_WORD;
   logic        hreadyout_o, hresp_o, chain_en_o, zmode_o, standby_o, tx_run_o, rx_run_o;
   logic        timer_run_o, rx_ext_a_o, tx_ext_a_o, rx_ext_b_o, tx_ext_b_o, ius_set_i;
   wire logic   hready_i;
   int          err_total = 0, comparisons = 0, seed = 32'hfc81;
   logic [7:0]  st;
   logic [31:0] exp_q[$];
   logic        rd_ph = 1'b0;
   logic [7:0]  lastb [2] = '{8'h00, 8'h00};

   umc_cmd_decoder dut_u (.*);
   umc_chain_peer peer_u (.mclk_i(mclk_i), .ack_i(ack), .ius_set_o(ius_set_i));
   assign hready_i = hreadyout_o;
   always #2.5 mclk_i = ~mclk_i;

   task tally_and_finish;
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Bounded wait for hready at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (hready_i !== 1'b1 && n < 64);
      if (n >= 64) begin
         err_total++;
         tally_and_finish();
      end
   endtask : wait_rdy

   // One AHB single transfer of the size left on hsize_i; reads note their expected data
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= UMC_HTRANS_NONSEQ;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      wait_rdy();
      htrans_i <= 2'b00;
      hsel_i <= 1'b0;
      hwdata_i <= w ? d : ~hwdata_i;
      if (!w)
         exp_q.push_back(d);
      wait_rdy();
   endtask : xfer

   // Issue a command, update the status model, read status back
   task send(input logic ch, input logic [3:0] c);
      logic [31:0] d;
      d = {24'($random(seed)), c, 4'($random(seed))};
      lastb[ch] = d[7:0];
      xfer(1'b1, ch ? UMC_OFS_CMD_B : UMC_OFS_CMD_A, d);
      case (c)
         UMC_CMD_SET_RX_EXT: st[UMC_ST_RX_EXT_A + 2 * ch] = 1'b1;
         UMC_CMD_CLR_RX_EXT: st[UMC_ST_RX_EXT_A + 2 * ch] = 1'b0;
         UMC_CMD_SET_TX_EXT: st[UMC_ST_TX_EXT_A + 2 * ch] = 1'b1;
         UMC_CMD_CLR_TX_EXT: st[UMC_ST_TX_EXT_A + 2 * ch] = 1'b0;
         UMC_CMD_STANDBY: if (!ch) st[UMC_ST_STANDBY] = 1'b1;
            else if (st[UMC_ST_ZMODE]) st[3:2] = 2'b10;
         UMC_CMD_ACTIVE: if (!ch) st[UMC_ST_STANDBY] = 1'b0;
            else st[UMC_ST_ZMODE] = 1'b1;
         default: ;
      endcase
      xfer(1'b0, UMC_OFS_STATUS, {24'h0, st});
   endtask : send

   // Acknowledge from the chain neighbour sets the latch in daisy mode
   task pulse;
      ack <= 1'b1;
      @(posedge mclk_i);
      ack <= 1'b0;
      repeat (3) @(posedge mclk_i);
      if (st[UMC_ST_ZMODE]) st[3:2] = 2'b01;
   endtask : pulse

   // Watch read data phases and compare with the oldest note
   always @(posedge mclk_i) begin
      if (rd_ph) begin
         comparisons++;
         if (hrdata_o !== exp_q[0]) begin
            err_total++;
            $display("wrong value hrdata_o expected %h seen %h", exp_q[0], hrdata_o);
         end
         void'(exp_q.pop_front());
      end
      rd_ph <= hsel_i && htrans_i[1] && !hwrite_i && hready_i;
   end

   // Main sequence: every code on both channels, then random traffic, then reset
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      st = 8'h08;
      xfer(1'b0, UMC_OFS_STATUS, 32'h8);
      xfer(1'b0, 8'h0c, 32'h0);
      for (int i = 0; i < 64; i++) begin
         if ($random(seed) & 1)
            pulse();
         if (i < 16)
            send(i[3], 4'h8 | i[2:0]);
         else
            send(1'($random(seed)), {i[0] | i[1], 3'($random(seed))});
      end
      xfer(1'b0, UMC_OFS_CMD_A, {24'h0, lastb[0]});
      xfer(1'b0, UMC_OFS_CMD_B, {24'h0, lastb[1]});
      // A byte-sized write must be ignored
      hsize_i <= 3'b000;
      xfer(1'b1, UMC_OFS_CMD_A, {24'h0, st[0] ? UMC_CMD_ACTIVE : UMC_CMD_STANDBY, 4'h0});
      hsize_i <= UMC_HSIZE_WORD;
      xfer(1'b0, UMC_OFS_STATUS, {24'h0, st});
      send(1'b0, UMC_CMD_STANDBY);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      st = 8'h08;
      xfer(1'b0, UMC_OFS_STATUS, 32'h8);
      xfer(1'b0, UMC_OFS_CMD_A, 32'h0);
      // Let the last data phase be compared before the verdict
      @(posedge mclk_i);
      if (exp_q.size() != 0) begin
         err_total++;
         $display("wrong value exp_q size expected 0 seen %0d", exp_q.size());
      end
      tally_and_finish();
   end
endmodule : test_uart_misc_command_decoder
